/* File: src/serial_handshake_port.sv */
// Host-side serial port: receive/transmit framing, link FIFO, handshake
// lines and status lamps. Inputs are synchronous to ref_clk.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // byte_fifo

////////////////////////////////////////////////////////////////////////////////
module serial_handshake_port #(
    parameter int BAUD_DIV     = serial_port_pkg::CLK_HZ
                                 / serial_port_pkg::DEFAULT_BAUD,
    parameter int RING_CYCLES  = serial_port_pkg::RING_CYCLES,
    parameter int STROBE_CYCLES = serial_port_pkg::STROBE_CYCLES,
    parameter int LAMP_CYCLES  = serial_port_pkg::LAMP_CYCLES,
    parameter int FIFO_DEPTH   = 8,
    parameter bit WIRELESS     = 1'b0
) (
    input  wire logic                           ref_clk,
    input  wire logic                           reset,
    // Host serial lines
    input  wire logic                           txd,
    output logic                                rxd,
    input  wire logic                           rts_n,
    output logic                                cts_n,
    input  wire logic                           dtr_n,
    output logic                                dsr_n,
    output logic                                dcd_n,
    output logic                                ri_n,
    // Local side of the modem
    input  wire serial_port_pkg::byte_beat_type link_rx,
    output logic                                link_rx_ready,
    input  wire serial_port_pkg::byte_beat_type resp,
    output logic                                resp_ready,
    output serial_port_pkg::byte_beat_type      host_tx,
    input  wire logic                           host_tx_ready,
    input  wire logic                           unit_ready,
    input  wire logic                           carrier_up,
    input  wire logic                           ring_on,
    input  wire logic                           offhook_req,
    output logic                                offhook,
    output logic                                disconnect,
    input  wire logic                           usb_vbus,
    output logic                                usb_available,
    // Lamps
    output logic                                connect_lamp_out,
    output logic                                receive_lamp_out,
    output logic                                transmit_lamp_out,
    output logic                                terminal_ready_lamp_out
);
    localparam int BW = $clog2(BAUD_DIV + 1);
    localparam int RW = $clog2(RING_CYCLES + 1);
    localparam int LW = $clog2(LAMP_CYCLES + 1);

    serial_port_pkg::tx_state_type tx_state_q;
    serial_port_pkg::rx_state_type rx_state_q;
    logic [BW-1:0] tx_cnt_q;
    logic [BW-1:0] rx_cnt_q;
    logic [2:0]    tx_bit_q;
    logic [2:0]    rx_bit_q;
    logic [7:0]    tx_sh_q;
    logic [7:0]    rx_sh_q;
    logic          fifo_valid;
    logic [7:0]    fifo_data;
    logic          fifo_pop;
    logic          load_resp;
    logic          load_link;
    logic          host_full_q;
    logic [RW-1:0] ring_cnt_q;
    logic [LW-1:0] rx_lamp_q;
    logic [LW-1:0] tx_lamp_q;
    logic          tx_tick;
    logic          rx_tick;

    // Link data waits here while the host holds off or responses run first
    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_link_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (link_rx.valid),
        .in_ready  (link_rx_ready),
        .in_data   (link_rx.data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Toward host: one serialiser shared by responses and link data
    assign tx_tick = tx_cnt_q == BW'(BAUD_DIV - 1);
    assign load_resp = tx_state_q == serial_port_pkg::TX_IDLE && !rts_n
                       && resp.valid;
    assign load_link = tx_state_q == serial_port_pkg::TX_IDLE && !rts_n
                       && !resp.valid && fifo_valid;
    assign resp_ready = load_resp;
    assign fifo_pop   = load_link;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            tx_state_q <= serial_port_pkg::TX_IDLE;
            tx_cnt_q   <= '0;
            tx_bit_q   <= '0;
            tx_sh_q    <= '0;
            rxd        <= serial_port_pkg::MARK_LEVEL;
        end
        else
        begin
            tx_cnt_q <= (tx_state_q == serial_port_pkg::TX_IDLE || tx_tick)
                        ? '0 : tx_cnt_q + 1'b1;
            case (tx_state_q)
                serial_port_pkg::TX_IDLE:
                begin
                    rxd <= serial_port_pkg::MARK_LEVEL;
                    if (load_resp || load_link)
                    begin
                        tx_sh_q    <= load_resp ? resp.data : fifo_data;
                        rxd        <= serial_port_pkg::SPACE_LEVEL;
                        tx_state_q <= serial_port_pkg::TX_START;
                    end
                end
                serial_port_pkg::TX_START:
                begin
                    if (tx_tick)
                    begin
                        rxd        <= tx_sh_q[0];
                        tx_sh_q    <= tx_sh_q >> 1;
                        tx_bit_q   <= '0;
                        tx_state_q <= serial_port_pkg::TX_DATA;
                    end
                end
                serial_port_pkg::TX_DATA:
                begin
                    if (tx_tick)
                    begin
                        tx_bit_q <= tx_bit_q + 1'b1;
                        rxd      <= tx_sh_q[0];
                        tx_sh_q  <= tx_sh_q >> 1;
                        if (tx_bit_q == 3'(serial_port_pkg::DATA_BITS - 1))
                        begin
                            rxd        <= serial_port_pkg::MARK_LEVEL;
                            tx_state_q <= serial_port_pkg::TX_STOP;
                        end
                    end
                end
                serial_port_pkg::TX_STOP:
                begin
                    if (tx_tick)
                    begin
                        tx_state_q <= serial_port_pkg::TX_IDLE;
                    end
                end
                default:
                begin
                    tx_state_q <= serial_port_pkg::TX_IDLE;
                    rxd        <= serial_port_pkg::MARK_LEVEL;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // From host: sampled at mid-bit; line assumed at mark between frames
    assign rx_tick = rx_cnt_q == BW'(BAUD_DIV - 1);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rx_state_q  <= serial_port_pkg::RX_IDLE;
            rx_cnt_q    <= '0;
            rx_bit_q    <= '0;
            rx_sh_q     <= '0;
            host_tx     <= '0;
        end
        else
        begin
            rx_cnt_q <= rx_tick ? '0 : rx_cnt_q + 1'b1;
            if (host_tx.valid && host_tx_ready)
            begin
                host_tx.valid <= 1'b0;
            end
            case (rx_state_q)
                serial_port_pkg::RX_IDLE:
                begin
                    if (txd == serial_port_pkg::SPACE_LEVEL)
                    begin
                        rx_cnt_q   <= BW'(BAUD_DIV / 2);
                        rx_state_q <= serial_port_pkg::RX_START;
                    end
                end
                serial_port_pkg::RX_START:
                begin
                    if (rx_tick)
                    begin
                        rx_bit_q   <= '0;
                        rx_state_q <= (txd == serial_port_pkg::SPACE_LEVEL)
                                      ? serial_port_pkg::RX_DATA
                                      : serial_port_pkg::RX_IDLE;
                    end
                end
                serial_port_pkg::RX_DATA:
                begin
                    if (rx_tick)
                    begin
                        rx_sh_q  <= {txd, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 1'b1;
                        if (rx_bit_q == 3'(serial_port_pkg::DATA_BITS - 1))
                        begin
                            rx_state_q <= serial_port_pkg::RX_STOP;
                        end
                    end
                end
                serial_port_pkg::RX_STOP:
                begin
                    if (rx_tick)
                    begin
                        // Framing errors and overruns drop the byte
                        if (txd == serial_port_pkg::MARK_LEVEL && !host_full_q)
                        begin
                            host_tx.valid <= 1'b1;
                            host_tx.data  <= rx_sh_q;
                        end
                        rx_state_q <= serial_port_pkg::RX_IDLE;
                    end
                end
                default:
                begin
                    rx_state_q <= serial_port_pkg::RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Handshake lines
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            host_full_q <= 1'b0;
        end
        else
        begin
            host_full_q <= host_tx.valid && !host_tx_ready;
        end
    end

    assign cts_n = host_full_q || !unit_ready;
    assign dsr_n = !unit_ready;
    assign dcd_n      = !(carrier_up && !dtr_n);
    assign disconnect = dtr_n;
    assign offhook    = offhook_req && ri_n && !dtr_n;
    assign usb_available = usb_vbus;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ring_cnt_q <= '0;
            ri_n       <= 1'b1;
        end
        else if (WIRELESS)
        begin
            ring_cnt_q <= (ring_cnt_q == RW'(RING_CYCLES - 1))
                          ? '0 : ring_cnt_q + 1'b1;
            ri_n       <= !(ring_cnt_q < RW'(STROBE_CYCLES));
        end
        else
        begin
            ri_n <= !ring_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lamps: receive and transmit lamps stretched so short bursts stay visible
    // activity lamps
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rx_lamp_q <= '0;
            tx_lamp_q <= '0;
        end
        else
        begin
            rx_lamp_q <= (rxd == serial_port_pkg::SPACE_LEVEL)
                         ? LW'(LAMP_CYCLES)
                         : (rx_lamp_q != '0 ? rx_lamp_q - 1'b1 : '0);
            tx_lamp_q <= (txd == serial_port_pkg::SPACE_LEVEL)
                         ? LW'(LAMP_CYCLES)
                         : (tx_lamp_q != '0 ? tx_lamp_q - 1'b1 : '0);
        end
    end

    assign receive_lamp_out        = rx_lamp_q != '0;
    assign transmit_lamp_out       = tx_lamp_q != '0;
    assign terminal_ready_lamp_out = !dtr_n;
    assign connect_lamp_out        = !dcd_n;
endmodule // serial_handshake_port

/* File: src/serial_port_pkg.sv */
// Constants and carrier types for the modem host serial handshake port.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
//
// Functional notes
// - Hold receive data while rts_n is high
// - Link data and responses share receive line
// - Command response goes before link data
// - Receive line idles at mark level
// - ri_n low during each ring on segment
// - No off-hook while ri_n is asserted
// - Wireless variant pulses ri_n once per second
// - dsr_n reflects local unit state only
// - Connection lamp active high while connected
// - USB available only while bus voltage present
// - cts_n low when transmit data will be taken
// - dcd_n low while data connection established
// - dtr_n low keeps connection, high disconnects
package serial_port_pkg;

    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned DEFAULT_BAUD   = 115_200;
    localparam int unsigned DATA_BITS      = 8;
    localparam int unsigned FRAME_BITS     = DATA_BITS + 2;
    localparam int unsigned RING_PERIOD_MS = 1000;
    localparam int unsigned STROBE_MS      = 100;
    localparam int unsigned LAMP_HOLD_MS   = 50;
    localparam int unsigned RING_CYCLES    = CLK_HZ / 1000 * RING_PERIOD_MS;
    localparam int unsigned STROBE_CYCLES  = CLK_HZ / 1000 * STROBE_MS;
    localparam int unsigned LAMP_CYCLES    = CLK_HZ / 1000 * LAMP_HOLD_MS;
    localparam logic        MARK_LEVEL     = 1'b1;
    localparam logic        SPACE_LEVEL    = 1'b0;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_beat_type;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'h1,
        TX_START = 4'h2,
        TX_DATA  = 4'h4,
        TX_STOP  = 4'h8
    } tx_state_type;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } rx_state_type;

endpackage

/* File: test/port_chk.sv */
// Checker for the host serial handshake port, bound to its top module.
// Assumes the single ref_clk domain with synchronous active-high reset.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module port_chk #(
    parameter int BAUD_DIV = 8,
    parameter bit WIRELESS = 1'b0
) (
    input wire logic                           ref_clk,
    input wire logic                           reset,
    input wire logic                           rxd,
    input wire logic                           rts_n,
    input wire logic                           cts_n,
    input wire logic                           dtr_n,
    input wire logic                           dsr_n,
    input wire logic                           dcd_n,
    input wire logic                           ri_n,
    input wire logic                           resp_ready,
    input wire serial_port_pkg::byte_beat_type host_tx,
    input wire logic                           host_tx_ready,
    input wire logic                           unit_ready,
    input wire logic                           carrier_up,
    input wire logic                           ring_on,
    input wire logic                           offhook,
    input wire logic                           disconnect,
    input wire logic                           usb_vbus,
    input wire logic                           usb_available,
    input wire logic                           connect_lamp_out,
    input wire logic                           receive_lamp_out,
    input wire logic                           terminal_ready_lamp_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Counts the start bit cycles after a response is taken
    int start_cnt_q;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            start_cnt_q <= 0;
        else if (resp_ready)
            start_cnt_q <= 1;
        else if (start_cnt_q != 0 && start_cnt_q < BAUD_DIV)
            start_cnt_q <= start_cnt_q + 1;
        else
            start_cnt_q <= 0;
    end

    resp_hold_a: assert property (resp_ready |-> !rts_n)
        else $error("response taken while host holds off");
    start_bit_a: assert property (start_cnt_q != 0 |-> !rxd)
        else $error("start bit missing after response");
    ring_low_a: assert property (!WIRELESS && ring_on |=> !ri_n)
        else $error("ring indicate not low during ring");
    ring_high_a: assert property (!WIRELESS && !ring_on |=> ri_n)
        else $error("ring indicate low without ring");
    no_offhook_a: assert property (offhook |-> ri_n)
        else $error("off-hook while ring indicate active");
    dsr_local_a: assert property (dsr_n == !unit_ready)
        else $error("data set ready not from local unit");
    connect_lamp_a: assert property (connect_lamp_out == !dcd_n)
        else $error("connection lamp wrong");
    carrier_out_a: assert property
        (dcd_n == !(carrier_up && !dtr_n))
        else $error("carrier detect wrong");
    usb_sense_a: assert property (usb_available == usb_vbus)
        else $error("usb availability wrong");
    term_follow_a: assert property
        (disconnect == dtr_n && terminal_ready_lamp_out == !dtr_n)
        else $error("terminal ready handling wrong");
    rx_lamp_a: assert property
        ($fell(rxd) |-> ##[0:2] receive_lamp_out)
        else $error("receive lamp not lit");
    stall_cts_a: assert property
        (host_tx.valid && !host_tx_ready |=> cts_n)
        else $error("clear to send while stalled");

    cover property (resp_ready);
    cover property (host_tx.valid && host_tx_ready);
    cover property (ring_on && !ri_n);
    cover property (WIRELESS && $fell(ri_n));
endmodule // port_chk

bind serial_handshake_port port_chk #(
    .BAUD_DIV(BAUD_DIV), .WIRELESS(WIRELESS)) u_chk (
    .ref_clk, .reset, .rxd, .rts_n, .cts_n, .dtr_n, .dsr_n, .dcd_n, .ri_n,
    .resp_ready, .host_tx, .host_tx_ready, .unit_ready, .carrier_up,
    .ring_on, .offhook, .disconnect, .usb_vbus, .usb_available,
    .connect_lamp_out, .receive_lamp_out, .terminal_ready_lamp_out
);

/* File: test/host_dte_model.sv */
// Behavioural host terminal: drives txd and rts_n, decodes rxd frames.
// Assumes 8N1 frames of BAUD_DIV clocks per bit.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module host_dte_model #(
    parameter int BAUD_DIV = 8
) (
    input  wire logic ref_clk,
    input  wire logic rxd,
    output logic      txd,
    output logic      rts_n
);
    initial txd = 1'b1;
    initial rts_n = 1'b1;

    task set_rts(input logic v);
        @(posedge ref_clk);
        rts_n <= v;
    endtask

    task send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge ref_clk);
            txd <= f[i];
            repeat (BAUD_DIV - 1) @(posedge ref_clk);
        end
    endtask

    // Samples mid-bit; ok only if the stop bit is at mark
    task recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        // Skip the launching edge so the start bit is seen settled
        @(negedge ref_clk);
        while (rxd === 1'b1 && n < 4000)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (rxd !== 1'b0)
            return;
        repeat (BAUD_DIV / 2) @(negedge ref_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BAUD_DIV) @(negedge ref_clk);
            b[i] = rxd;
        end
        repeat (BAUD_DIV) @(negedge ref_clk);
        ok = (rxd === 1'b1);
    endtask
endmodule // host_dte_model

/* File: test/tb.sv */
// Self-checking bench for the host serial handshake port.
// Assumes short counts: 8 clocks a bit, 8-entry link FIFO.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module tb;
    logic ref_clk = 1'b0;
    logic reset;
    logic txd, rxd, rts_n, cts_n, dsr_n, dcd_n, ri_n, ri_w_n;
    logic dtr_n, unit_ready, carrier_up;
    logic ring_on, offhook_req, usb_vbus;
    logic host_tx_ready;
    logic link_rx_ready, resp_ready, offhook, disconnect, usb_available;
    logic lamp_c, lamp_r, lamp_t, lamp_d;
    serial_port_pkg::byte_beat_type link_rx, resp, host_tx;
    int n_mismatch = 0, n_tests = 0;

    always #4 ref_clk = ~ref_clk;

    host_dte_model #(.BAUD_DIV(8)) host (.ref_clk(ref_clk), .rxd(rxd),
        .txd(txd), .rts_n(rts_n));

    serial_handshake_port #(.BAUD_DIV(8), .RING_CYCLES(100),
        .STROBE_CYCLES(10), .LAMP_CYCLES(20), .FIFO_DEPTH(8),
        .WIRELESS(1'b0)) uut (
        .ref_clk(ref_clk), .reset(reset), .txd(txd), .rxd(rxd),
        .rts_n(rts_n), .cts_n(cts_n), .dtr_n(dtr_n), .dsr_n(dsr_n),
        .dcd_n(dcd_n), .ri_n(ri_n), .link_rx(link_rx),
        .link_rx_ready(link_rx_ready), .resp(resp),
        .resp_ready(resp_ready), .host_tx(host_tx),
        .host_tx_ready(host_tx_ready), .unit_ready(unit_ready),
        .carrier_up(carrier_up), .ring_on(ring_on),
        .offhook_req(offhook_req), .offhook(offhook),
        .disconnect(disconnect), .usb_vbus(usb_vbus),
        .usb_available(usb_available), .connect_lamp_out(lamp_c),
        .receive_lamp_out(lamp_r), .transmit_lamp_out(lamp_t),
        .terminal_ready_lamp_out(lamp_d));

    // Wireless build: shares the inputs, only its ring strobe is watched
    serial_handshake_port #(.BAUD_DIV(8), .RING_CYCLES(100),
        .STROBE_CYCLES(10), .LAMP_CYCLES(20), .FIFO_DEPTH(8),
        .WIRELESS(1'b1)) uut_wireless (
        .ref_clk(ref_clk), .reset(reset), .txd(txd), .rxd(),
        .rts_n(rts_n), .cts_n(), .dtr_n(dtr_n), .dsr_n(),
        .dcd_n(), .ri_n(ri_w_n), .link_rx(link_rx),
        .link_rx_ready(), .resp(resp), .resp_ready(), .host_tx(),
        .host_tx_ready(host_tx_ready), .unit_ready(unit_ready),
        .carrier_up(carrier_up), .ring_on(ring_on),
        .offhook_req(offhook_req), .offhook(), .disconnect(),
        .usb_vbus(usb_vbus), .usb_available(), .connect_lamp_out(),
        .receive_lamp_out(), .transmit_lamp_out(),
        .terminal_ready_lamp_out());

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Holds the response until it is taken, bounded wait
    task take_resp;
        for (int k = 0; k < 400 && resp_ready !== 1'b1; k++)
            @(negedge ref_clk);
        chk({7'h00, resp_ready}, 8'h01);
        @(posedge ref_clk);
        resp.valid <= 1'b0;
    endtask

    task t_resp;
        logic [7:0] b;
        logic ok;
        host.set_rts(1'b0);
        @(posedge ref_clk);
        resp <= {1'b1, 8'hA5};
        take_resp();
        host.recv_byte(b, ok);
        chk(b, 8'hA5);
        chk({7'h00, ok}, 8'h01);
        chk({7'h00, lamp_r}, 8'h01);
        $display("response frame test done");
    endtask

    // Fills the FIFO while held off, then the response must lead
    task t_order;
        logic [7:0] b;
        logic ok;
        int n;
        n = 0;
        host.set_rts(1'b1);
        repeat (2 * 10 * 8) @(posedge ref_clk);
        for (int k = 0; k < 12; k++)
        begin
            @(posedge ref_clk);
            link_rx <= {1'b1, 8'h10 + 8'(n)};
            @(negedge ref_clk);
            if (link_rx_ready !== 1'b1)
                break;
            n++;
        end
        @(posedge ref_clk);
        link_rx.valid <= 1'b0;
        chk(8'(n), 8'h08);
        resp <= {1'b1, 8'hE7};
        repeat (20) @(negedge ref_clk);
        chk({7'h00, rxd}, 8'h01);
        host.set_rts(1'b0);
        take_resp();
        host.recv_byte(b, ok);
        chk(b, 8'hE7);
        for (int k = 0; k < 8; k++)
        begin
            host.recv_byte(b, ok);
            chk(b, 8'h10 + 8'(k));
            chk({7'h00, ok}, 8'h01);
        end
        $display("priority and fifo test done");
    endtask

    task t_txd;
        @(posedge ref_clk);
        host_tx_ready <= 1'b0;
        @(negedge ref_clk);
        chk({7'h00, cts_n}, 8'h00);
        // Last data bit is a space so the lamp is still lit at the check
        host.send_byte(8'h3C);
        @(negedge ref_clk);
        for (int k = 0; k < 40 && host_tx.valid !== 1'b1; k++)
            @(negedge ref_clk);
        chk(host_tx.data, 8'h3C);
        chk({7'h00, cts_n}, 8'h01);
        chk({7'h00, lamp_t}, 8'h01);
        @(posedge ref_clk);
        host_tx_ready <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({7'h00, host_tx.valid}, 8'h00);
        $display("transmit line test done");
    endtask

    task t_ring;
        @(posedge ref_clk);
        unit_ready <= 1'b0;
        offhook_req <= 1'b1;
        ring_on <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({5'h00, dsr_n, ri_n, offhook}, 8'h04);
        @(posedge ref_clk);
        ring_on <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({5'h00, dsr_n, ri_n, offhook}, 8'h07);
        $display("ring test done");
    endtask

    task t_strobe;
        int lo;
        lo = 0;
        for (int k = 0; k < 100; k++)
        begin
            @(negedge ref_clk);
            if (ri_w_n === 1'b0)
                lo++;
        end
        chk(8'(lo), 8'h0A);
        $display("wireless strobe test done");
    endtask

    task t_status;
        logic [3:0] v;
        for (int k = 0; k < 16; k++)
        begin
            v = 4'(k);
            @(posedge ref_clk);
            {unit_ready, carrier_up, dtr_n, usb_vbus} <= v;
            @(negedge ref_clk);
            chk({7'h00, dsr_n}, {7'h00, !v[3]});
            chk({7'h00, dcd_n}, {7'h00, !(v[2] && !v[1])});
            chk({7'h00, lamp_c}, {7'h00, v[2] && !v[1]});
            chk({6'h00, disconnect, lamp_d}, {6'h00, v[1], !v[1]});
            chk({7'h00, usb_available}, {7'h00, v[0]});
        end
        $display("status lines test done");
    endtask

    initial
    begin
        reset         <= 1'b1;
        dtr_n         <= 1'b0;
        unit_ready    <= 1'b1;
        carrier_up    <= 1'b1;
        ring_on       <= 1'b0;
        offhook_req   <= 1'b0;
        usb_vbus      <= 1'b1;
        host_tx_ready <= 1'b1;
        link_rx       <= '0;
        resp          <= '0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_resp();
        t_order();
        t_txd();
        t_ring();
        t_status();
        t_strobe();
        close_out();
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end
endmodule // tb
